// ---- core/adcc_top.sv ----
/*
  adcc_top: converter control and completion interrupt logic.
  holds pin select, clock prescaler select and gate, channel select, start,
  10-bit result, interrupt priority, enable and flag registers.
  assumes: clk_sys domain; fast and slow oscillator clocks arrive as async
  levels and are sampled here; the analog core returns a result sample on
  adc_sample_data when it is asked on adc_sample_req.
*/
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int CONV_TICKS = ADCC_CONV_TICKS
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        fast_osc_clock,
  input  wire logic        slow_osc_clock,
  input  wire logic [9:0]  adc_sample_data,
  input  wire logic [1:0]  cpu_irq_mask_level,
  output logic      [3:0]  analog_pin_select,
  output logic      [1:0]  analog_channel_active,
  output logic             converter_clock_out,
  output logic             adc_sample_req,
  output logic             conv_busy,
  output logic             converter_irq_req,
  output logic      [1:0]  converter_irq_level
);
// Functional notes
// [RQ1] pin select bits make port pins analog
// [RQ2] divider field picks fast divided or slow
// [RQ3] gate bit passes selected clock, reads zero
// [RQ4] writing start one begins selected channel conversion
// [RQ5] channel field selects analog input four to seven
// [RQ6] ten-bit result split high and low
// [RQ7] result undefined until first conversion
// [RQ8] priority field sets completion interrupt level
// [RQ9] enable bit permits completion interrupt
// [RQ10] flag set when conversion finishes
// [RQ11] flag sets regardless of enable, priority
// [RQ12] request needs flag, enable, level above mask
// [RQ13] write one clears flag, reset clears
// [RQ14] software clears flag and lowers mask
// [RQ15] start only with clock, keep clock running
// [RQ16] change clock, pins only while idle
// [RQ17] channel must be an analog pin
// [RQ18] result and flag update together
// [RQ19] start during conversion is ignored

  localparam int TICK_W = $clog2(CONV_TICKS + 1);

  // registered state
  logic [3:0]            pin_sel_reg;
  logic [2:0]            div_sel_reg;
  logic                  gate_reg;
  logic [1:0]            chan_reg;
  logic [1:0]            conv_chan_reg;
  logic [1:0]            prio_reg;
  logic                  ien_reg;
  logic                  flag_reg;
  logic [9:0]            result_reg;
  logic                  busy_reg;
  logic [TICK_W-1:0]     tick_cnt_reg;
  logic [2:0]            fast_pipe_reg;
  logic [2:0]            slow_pipe_reg;
  logic                  fast_lvl_reg;
  logic                  slow_lvl_reg;
  logic [ADCC_PRE_W-1:0] pre_cnt_reg;
  logic                  conv_clk_reg;
  logic                  conv_clk_prev_reg;
  logic                  done_reg;
  logic [7:0]            rdata_reg;
  logic                  req_reg;

  // decode and next-state nets
  logic                  wr_prio;
  logic                  wr_ien;
  logic                  wr_iflag;
  logic                  wr_clk;
  logic                  wr_pin;
  logic                  wr_start;
  logic                  start_go;
  logic                  fast_rise;
  logic                  slow_rise;
  logic                  sel_clk_next;
  logic                  conv_tick;
  logic                  conv_end;
  logic [7:0]            rdata_next;

  // address match shared by write decode and read mux
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction : hit

  // register write decode
  assign wr_prio  = reg_wr && hit(reg_addr, ADCC_OFS_PRIO);
  assign wr_ien   = reg_wr && hit(reg_addr, ADCC_OFS_IEN);
  assign wr_iflag = reg_wr && hit(reg_addr, ADCC_OFS_IFLAG);
  assign wr_clk   = reg_wr && hit(reg_addr, ADCC_OFS_CLKCTL);
  assign wr_pin   = reg_wr && hit(reg_addr, ADCC_OFS_PINSEL);
  assign wr_start = reg_wr && hit(reg_addr, ADCC_OFS_START);
  assign start_go = wr_start && reg_wdata[ADCC_START_BIT] && !busy_reg; // [RQ4] [RQ19]

  // software control registers, one process per register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_sel_reg <= ADCC_PIN_RST;
    end else if (wr_pin) begin
      pin_sel_reg <= reg_wdata[ADCC_PIN_LSB +: 4]; // [RQ1]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_sel_reg <= ADCC_DIV_RST;
      gate_reg    <= 1'b0;
    end else if (wr_clk) begin
      div_sel_reg <= reg_wdata[ADCC_DIV_LSB +: 3]; // [RQ2]
      gate_reg    <= reg_wdata[ADCC_GATE_BIT]; // [RQ3]
    end
  end

  // channel field is written even while busy; the running conversion keeps its own copy
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      chan_reg <= ADCC_CHAN_RST;
    end else if (wr_start) begin
      chan_reg <= reg_wdata[ADCC_CHAN_LSB +: 2]; // [RQ5]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prio_reg <= ADCC_PRIO_RST;
    end else if (wr_prio) begin
      prio_reg <= reg_wdata[ADCC_PRIO_LSB +: 2]; // [RQ8]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ien_reg <= 1'b0;
    end else if (wr_ien) begin
      ien_reg <= reg_wdata[ADCC_IEN_BIT]; // [RQ9]
    end
  end

  // oscillator inputs: three-stage sampling, edge when stages two and three agree
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fast_pipe_reg <= ADCC_PIPE_RST;
      fast_lvl_reg  <= 1'b0;
    end else begin
      fast_pipe_reg <= {fast_pipe_reg[1:0], fast_osc_clock};
      if (fast_pipe_reg[1] == fast_pipe_reg[2]) begin
        fast_lvl_reg <= fast_pipe_reg[2];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      slow_pipe_reg <= ADCC_PIPE_RST;
      slow_lvl_reg  <= 1'b0;
    end else begin
      slow_pipe_reg <= {slow_pipe_reg[1:0], slow_osc_clock};
      if (slow_pipe_reg[1] == slow_pipe_reg[2]) begin
        slow_lvl_reg <= slow_pipe_reg[2];
      end
    end
  end

  function automatic logic settled_rise(input logic [2:0] pipe, input logic lvl);
    return (pipe[1] == pipe[2]) && pipe[2] && !lvl;
  endfunction : settled_rise

  assign fast_rise = settled_rise(fast_pipe_reg, fast_lvl_reg);
  assign slow_rise = settled_rise(slow_pipe_reg, slow_lvl_reg);

  // prescaler: a free counter of fast clock edges; its bits are the divided clocks
  always_comb begin
    case (div_sel_reg) // [RQ2]
      ADCC_DIV_SLOW: sel_clk_next = slow_lvl_reg;
      3'h0:          sel_clk_next = fast_lvl_reg;
      default:       sel_clk_next = pre_cnt_reg[div_sel_reg - 3'h1];
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt_reg <= '0;
    end else if (fast_rise) begin
      pre_cnt_reg <= pre_cnt_reg + 1'b1;
    end
  end

  // gated clock and its delayed copy give one tick per converter clock rise
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      conv_clk_reg      <= 1'b0;
      conv_clk_prev_reg <= 1'b0;
    end else begin
      conv_clk_reg      <= gate_reg && sel_clk_next; // [RQ3]
      conv_clk_prev_reg <= conv_clk_reg;
    end
  end

  assign conv_tick = conv_clk_reg && !conv_clk_prev_reg;

  // conversion sequencer: counts gated converter clock ticks
  assign conv_end = busy_reg && conv_tick && (tick_cnt_reg == TICK_W'(CONV_TICKS - 1));

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
    end else if (start_go) begin
      busy_reg <= 1'b1; // [RQ4]
    end else if (conv_end) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_reg <= '0;
    end else if (start_go) begin
      tick_cnt_reg <= '0;
    end else if (busy_reg && conv_tick && !conv_end) begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      conv_chan_reg <= ADCC_CHAN_RST;
    end else if (start_go) begin
      conv_chan_reg <= reg_wdata[ADCC_CHAN_LSB +: 2]; // [RQ5] [RQ19]
    end
  end

  // sample request pulse to the analog core
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= conv_end;
    end
  end

  // result capture strobe, high in the same cycle as the sample request
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      req_reg <= 1'b0;
    end else begin
      req_reg <= conv_end;
    end
  end

  // result capture; no reset so content is undefined until first completion
  always_ff @(posedge clk_sys) begin
    if (req_reg) begin
      result_reg <= adc_sample_data; // [RQ6] [RQ7] [RQ18]
    end
  end

  // completion flag: set wins over a same-cycle write-one clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flag_reg <= 1'b0; // [RQ13]
    end else if (req_reg) begin
      flag_reg <= 1'b1; // [RQ10] [RQ11] [RQ18]
    end else if (wr_iflag && reg_wdata[ADCC_IFLAG_BIT]) begin
      flag_reg <= 1'b0; // [RQ13]
    end
  end

  // read mux; unmapped addresses return zero
  always_comb begin
    rdata_next = 8'h00;
    if (hit(reg_addr, ADCC_OFS_PRIO)) begin
      rdata_next[ADCC_PRIO_LSB +: 2] = prio_reg;
    end else if (hit(reg_addr, ADCC_OFS_IEN)) begin
      rdata_next[ADCC_IEN_BIT] = ien_reg;
    end else if (hit(reg_addr, ADCC_OFS_IFLAG)) begin
      rdata_next[ADCC_IFLAG_BIT] = flag_reg;
    end else if (hit(reg_addr, ADCC_OFS_CLKCTL)) begin
      rdata_next[ADCC_DIV_LSB +: 3] = div_sel_reg; // [RQ3]
    end else if (hit(reg_addr, ADCC_OFS_PINSEL)) begin
      rdata_next[ADCC_PIN_LSB +: 4] = pin_sel_reg;
    end else if (hit(reg_addr, ADCC_OFS_START)) begin
      rdata_next[ADCC_CHAN_LSB +: 2] = chan_reg; // [RQ4]
    end else if (hit(reg_addr, ADCC_OFS_RESHI)) begin
      rdata_next = result_reg[9:2]; // [RQ6]
    end else if (hit(reg_addr, ADCC_OFS_RESLO)) begin
      rdata_next[1:0] = result_reg[1:0]; // [RQ6]
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // interrupt request towards the processor, one cycle behind the flag
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      converter_irq_req <= 1'b0;
    end else begin
      converter_irq_req <= flag_reg && ien_reg && (prio_reg > cpu_irq_mask_level); // [RQ12]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      converter_irq_level <= ADCC_PRIO_RST;
    end else begin
      converter_irq_level <= prio_reg; // [RQ8]
    end
  end

  assign reg_rdata             = rdata_reg;
  assign analog_pin_select     = pin_sel_reg;
  assign analog_channel_active = conv_chan_reg;
  assign converter_clock_out   = conv_clk_reg;
  assign adc_sample_req        = done_reg;
  assign conv_busy             = busy_reg;
endmodule : adcc_top

// ---- common/adcc_pkg.sv ----
/*
  adcc_pkg: register offsets, field positions, reset values and timing counts
  for the converter control block.
  assumes a byte-wide peripheral register port with 16-bit addresses.
*/
package adcc_pkg;
  localparam logic [15:0] ADCC_OFS_PRIO   = 16'hff28;
  localparam logic [15:0] ADCC_OFS_IEN    = 16'hff2a;
  localparam logic [15:0] ADCC_OFS_IFLAG  = 16'hff2c;
  localparam logic [15:0] ADCC_OFS_CLKCTL = 16'hff80;
  localparam logic [15:0] ADCC_OFS_PINSEL = 16'hff81;
  localparam logic [15:0] ADCC_OFS_START  = 16'hff82;
  localparam logic [15:0] ADCC_OFS_RESHI  = 16'hff83;
  localparam logic [15:0] ADCC_OFS_RESLO  = 16'hff84;

  localparam int ADCC_PRIO_LSB   = 6;
  localparam int ADCC_IEN_BIT    = 7;
  localparam int ADCC_IFLAG_BIT  = 7;
  localparam int ADCC_GATE_BIT   = 3;
  localparam int ADCC_DIV_LSB    = 0;
  localparam int ADCC_PIN_LSB    = 4;
  localparam int ADCC_START_BIT  = 7;
  localparam int ADCC_CHAN_LSB   = 0;

  localparam logic [2:0]  ADCC_DIV_RST   = 3'h0;
  localparam logic [2:0]  ADCC_DIV_SLOW  = 3'h7;
  localparam logic [1:0]  ADCC_PRIO_RST  = 2'h0;
  localparam logic [1:0]  ADCC_CHAN_RST  = 2'h0;
  localparam logic [3:0]  ADCC_PIN_RST   = 4'h0;
  localparam logic [9:0]  ADCC_RES_RST   = 10'h000;

  // converter takes this many gated converter clock ticks per conversion
  localparam int          ADCC_CONV_TICKS = 16;
  localparam int          ADCC_PRE_W      = 6;
  localparam logic [2:0]  ADCC_PIPE_RST   = 3'h0;
endpackage : adcc_pkg

// ---- verif/adcc_monitor.sv ----
/* adcc_monitor: port assertions for adcc_top.
   assumes one clk_sys domain, bound into every adcc_top. */
`timescale 1ns/100ps
module adcc_monitor
  import adcc_pkg::*;
#(parameter int CONV_TICKS = ADCC_CONV_TICKS) (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [1:0]  cpu_irq_mask_level,
  input wire logic [3:0]  analog_pin_select,
  input wire logic [1:0]  analog_channel_active,
  input wire logic        adc_sample_req,
  input wire logic        conv_busy,
  input wire logic        converter_irq_req,
  input wire logic [1:0]  converter_irq_level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_PIN_SEL: assert property (reg_wr && reg_addr == ADCC_OFS_PINSEL
    |=> analog_pin_select == $past(reg_wdata[7:4])) else $error("pin select not loaded");
  AST_START_RD0: assert property ($past(reg_rd) && $past(reg_addr) == ADCC_OFS_START
    |-> !reg_rdata[7]) else $error("start bit read as one");
  AST_START_IDLE: assert property (!conv_busy && reg_wr && reg_addr == ADCC_OFS_START && reg_wdata[7]
    |=> conv_busy && analog_channel_active == $past(reg_wdata[1:0])) else $error("start not taken");
  AST_RESLO_PAD: assert property ($past(reg_rd) && $past(reg_addr) == ADCC_OFS_RESLO
    |-> reg_rdata[7:2] == 6'h00) else $error("result low pad bits set");
  AST_PRIO_LVL: assert property (reg_wr && reg_addr == ADCC_OFS_PRIO
    |-> ##2 converter_irq_level == $past(reg_wdata[7:6], 2)) else $error("level not loaded");
  AST_IRQ_MASK: assert property (converter_irq_req
    |-> converter_irq_level > $past(cpu_irq_mask_level)) else $error("request not above mask");
  AST_BUSY_HOLD: assert property (conv_busy && reg_wr && reg_addr == ADCC_OFS_START
    |=> $stable(analog_channel_active) && conv_busy) else $error("restart while busy");
  AST_DONE: assert property ($rose(adc_sample_req) |-> $fell(conv_busy))
    else $error("sample without end of busy");
endmodule : adcc_monitor

bind adcc_top adcc_monitor #(.CONV_TICKS(CONV_TICKS)) u_mon (.clk_sys, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_irq_mask_level, .analog_pin_select,
  .analog_channel_active, .adc_sample_req, .conv_busy, .converter_irq_req, .converter_irq_level);

// ---- verif/adcc_analog_model.sv ----
/* adcc_analog_model: oscillators and analog core sample source.
   assumes data is taken only while adc_sample_req is high. */
`timescale 1ns/100ps
module adcc_analog_model (
  input  wire logic [1:0] analog_channel_active,
  input  wire logic       adc_sample_req,
  output logic            fast_osc_clock,
  output logic            slow_osc_clock,
  output logic      [9:0] adc_sample_data
);
  initial fast_osc_clock = 1'b0;
  initial slow_osc_clock = 1'b0;
  always #20 fast_osc_clock = ~fast_osc_clock;
  always #400 slow_osc_clock = ~slow_osc_clock;
  // value tied to channel, inverted outside the sample cycle
  assign adc_sample_data = adc_sample_req ? {analog_channel_active, 8'h96}
                                          : ~{analog_channel_active, 8'h96};
endmodule : adcc_analog_model

// ---- verif/testbench.sv ----
/* testbench: register bus tests of adcc_top.
   assumes the analog model answers every sample request. */
`timescale 1ns/100ps
module testbench;
  import adcc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [1:0]  cpu_irq_mask_level = 2'h0;
  logic [7:0]  reg_rdata, d;
  logic [3:0]  analog_pin_select;
  logic [1:0]  analog_channel_active;
  logic        fast_osc_clock, slow_osc_clock;
  logic [9:0]  adc_sample_data, exp;
  logic        converter_clock_out, adc_sample_req, conv_busy, converter_irq_req;
  logic [1:0]  converter_irq_level;
  int          miscompares = 0;
  int          n_tests = 0;
  logic [15:0] ra [7] = '{ADCC_OFS_PRIO, ADCC_OFS_IEN, ADCC_OFS_IFLAG, ADCC_OFS_CLKCTL,
                          ADCC_OFS_PINSEL, ADCC_OFS_START, 16'hff30};
  logic [7:0]  cc [9] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h07};
  int          ce [9] = '{64, 32, 16, 8, 4, 2, 1, 3, 0};

  adcc_top #(.CONV_TICKS(2)) uut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .fast_osc_clock, .slow_osc_clock, .adc_sample_data, .cpu_irq_mask_level,
    .analog_pin_select, .analog_channel_active, .converter_clock_out, .adc_sample_req,
    .conv_busy, .converter_irq_req, .converter_irq_level);
  adcc_analog_model u_ana (.analog_channel_active, .adc_sample_req, .fast_osc_clock,
    .slow_osc_clock, .adc_sample_data);

  always #2 clk_sys = ~clk_sys;

  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask : rd
  task automatic wdone;
    int i;
    i = 0;
    @(negedge clk_sys);
    while (conv_busy !== 1'b0 && i < 500) begin
      @(negedge clk_sys);
      i++;
    end
    chk(conv_busy, 10'h0);
    chk(adc_sample_req, 10'h1);
  endtask : wdone
  task automatic ccount(input logic [7:0] c, input int e);
    int n;
    logic p;
    n = 0;
    wr(ADCC_OFS_CLKCTL, c);
    p = converter_clock_out;
    repeat (640) begin
      @(negedge clk_sys);
      if (!p && converter_clock_out) n++;
      p = converter_clock_out;
    end
    chk(10'(n >= e - 1 && n <= e + 1), 1);
  endtask : ccount
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i], d);
      chk(d, 0);
    end
    wr(ADCC_OFS_PINSEL, 8'hf0);
    rd(ADCC_OFS_PINSEL, d);
    chk(d, 8'hf0);
    chk(analog_pin_select, 4'hf);
    wr(ADCC_OFS_PRIO, 8'hc0);
    rd(ADCC_OFS_PRIO, d);
    chk(d, 8'hc0);
    chk(converter_irq_level, 10'h3);
    wr(ADCC_OFS_CLKCTL, 8'h0f);
    rd(ADCC_OFS_CLKCTL, d);
    chk(d, 8'h07);
    wr(ADCC_OFS_START, 8'h03);
    rd(ADCC_OFS_START, d);
    chk(d, 8'h03);
    chk(conv_busy, 0);
    foreach (cc[i]) ccount(cc[i], ce[i]);
    wr(ADCC_OFS_CLKCTL, 8'h08);
    for (int ch = 0; ch < 4; ch++) begin
      @(posedge clk_sys);
      cpu_irq_mask_level <= 2'(ch);
      wr(ADCC_OFS_IEN, (ch != 1) ? 8'h80 : 8'h00);
      wr(ADCC_OFS_START, 8'h80 | 8'(ch));
      if (ch == 2) wr(ADCC_OFS_START, 8'h81);
      wdone();
      exp = {2'(ch), 8'h96};
      chk(analog_channel_active, 10'(ch));
      repeat (3) @(negedge clk_sys);
      rd(ADCC_OFS_IFLAG, d);
      chk(d, 8'h80);
      chk(converter_irq_req, 10'(ch != 1 && ch < 3));
      rd(ADCC_OFS_RESHI, d);
      chk(d, exp[9:2]);
      rd(ADCC_OFS_RESLO, d);
      chk(d, {6'h00, exp[1:0]});
      wr(ADCC_OFS_IFLAG, 8'h00);
      rd(ADCC_OFS_IFLAG, d);
      chk(d, 8'h80);
      wr(ADCC_OFS_IFLAG, 8'h80);
      rd(ADCC_OFS_IFLAG, d);
      chk(d, 8'h00);
      chk(converter_irq_req, 0);
    end
    wrap_up();
  end
endmodule : testbench
